// >>> rtl/racd_pkg.sv
package racd_pkg;
  // command byte fields
  localparam int unsigned CMD_GATE_BIT = 7;
  localparam int unsigned CMD_DIR_BIT = 6;
  localparam int unsigned CMD_ADDR_MSB = 5;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // register map, by address code
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CMD = 6'h00;
  localparam logic [5:0] ADDR_ADC_MODE = 6'h01;
  localparam logic [5:0] ADDR_IF_MODE = 6'h02;
  localparam logic [5:0] ADDR_CHECKSUM = 6'h03;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  localparam logic [5:0] ADDR_GPIO = 6'h06;
  localparam logic [5:0] ADDR_IDENT = 6'h07;
  localparam logic [5:0] ADDR_CHAN_LO = 6'h10;
  localparam logic [5:0] ADDR_SETUP_LO = 6'h20;
  localparam logic [5:0] ADDR_FILT_LO = 6'h28;
  localparam logic [5:0] ADDR_OFFS_LO = 6'h30;
  // register widths in bytes; zero marks a reserved code
  localparam logic [1:0] LEN_NONE = 2'd0;
  localparam logic [1:0] LEN_STATUS = 2'd1;
  localparam logic [1:0] LEN_CTRL = 2'd2;
  localparam logic [1:0] LEN_WORD = 2'd3;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] TX_IDLE = 8'hff;
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'd7;
  localparam int unsigned DATA_W = 24;
  typedef enum logic [1:0] {RACD_WAIT_CMD, RACD_LOAD, RACD_XFER} racd_state_t;
endpackage

// >>> rtl/racd_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop level synchroniser
module racd_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic rst_val_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  // first flop feeds only the second
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      meta_q <= rst_val_i; // idle level of the crossing signal
      sync_o <= rst_val_i;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/racd_top.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - every register transfer must be opened by a command byte.
// - the latest command picks the target register and the direction.
// - a byte counts as a command only when its top bit is zero.
// - command bit six chooses write (0) or read (1).
// - the six low bits select the register from the address map.
// - the command register is eight bits, write-only, reset to zero.
// - a read of address zero returns the status register, reset 0x80.
module racd_top
  import racd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  input wire logic [7:0] status_i,
  input wire logic [DATA_W-1:0] reg_rdata_i,
  output logic [5:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [DATA_W-1:0] reg_wdata_o,
  output logic [7:0] cmd_o,
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  // link domain: byte deserialiser and read shifter
  logic frame_rst_n;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_byte_q;
  logic rx_tgl_q;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_byte_q;

  // frame end clears the bit position; the link clock may stop
  assign frame_rst_n = rst_n_i & ~cs_n_i;

  // sample on rising edge, publish each whole byte by toggle
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_q <= 3'd0;
      rx_sh_q <= 8'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      rx_sh_q <= {rx_sh_q[6:0], sdi_i};
    end
  end

  // byte holder and event toggle survive frame ends
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_byte_q <= 8'h00;
      rx_tgl_q <= 1'b0;
    end else if (!cs_n_i && bit_cnt_q == BIT_LAST) begin
      rx_byte_q <= {rx_sh_q[6:0], sdi_i};
      rx_tgl_q <= ~rx_tgl_q;
    end
  end

  // launch on falling edge; tx_byte_q is quiet when loaded
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_sh_q <= TX_IDLE;
    end else if (bit_cnt_q == 3'd0) begin
      tx_sh_q <= tx_byte_q;
    end else begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b1};
    end
  end

  assign sdo_o = tx_sh_q[7];

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the system clock
  logic tgl_s;
  logic tgl_seen_q;
  logic cs_n_s;
  logic byte_ev;

  racd_sync u_sync_tgl (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .rst_val_i(1'b0),
    .async_i(rx_tgl_q),
    .sync_o(tgl_s)
  );

  racd_sync u_sync_cs (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .rst_val_i(1'b1),
    .async_i(cs_n_i),
    .sync_o(cs_n_s)
  );

  // edge of the synchronised toggle marks one received byte
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
    end
  end

  assign byte_ev = tgl_s ^ tgl_seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  racd_state_t state_q;
  logic [7:0] cmd_q;
  logic [7:0] status_q;
  logic dir_rd_q;
  logic [1:0] left_q;
  logic [DATA_W-1:0] rd_val_q;
  logic [1:0] cmd_len;
  logic cmd_ok;

  // address code to register width
  function automatic logic [1:0] racd_len(input logic [5:0] a);
    logic [1:0] n;
    n = LEN_NONE;
    if (a == ADDR_STATUS) begin
      n = LEN_STATUS;
    end else if (a == ADDR_ADC_MODE || a == ADDR_IF_MODE) begin
      n = LEN_CTRL;
    end else if (a == ADDR_CHECKSUM || a == ADDR_DATA) begin
      n = LEN_WORD;
    end else if (a == ADDR_GPIO || a == ADDR_IDENT) begin
      n = LEN_CTRL;
    end else if (a >= ADDR_CHAN_LO && a < ADDR_OFFS_LO) begin
      n = LEN_CTRL;
    end else if (a >= ADDR_OFFS_LO) begin
      n = LEN_WORD;
    end
    return n;
  endfunction

  assign cmd_len = racd_len(rx_byte_q[CMD_ADDR_MSB:0]);
  assign cmd_ok = !rx_byte_q[CMD_GATE_BIT] && cmd_len != LEN_NONE;

  // transfer sequencer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || cs_n_s) begin
      state_q <= RACD_WAIT_CMD;
    end else begin
      unique case (state_q)
        RACD_WAIT_CMD: begin
          if (byte_ev && cmd_ok) begin
            state_q <= rx_byte_q[CMD_DIR_BIT] ? RACD_LOAD : RACD_XFER;
          end
        end
        RACD_LOAD: begin
          state_q <= RACD_XFER;
        end
        RACD_XFER: begin
          if (byte_ev && left_q == 2'd1) begin
            state_q <= RACD_WAIT_CMD;
          end
        end
      endcase
    end
  end

  // command register, written by every accepted command
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_RESET;
      dir_rd_q <= 1'b0;
      reg_addr_o <= ADDR_CMD;
    end else if (state_q == RACD_WAIT_CMD && byte_ev && cmd_ok) begin
      cmd_q <= rx_byte_q;
      dir_rd_q <= rx_byte_q[CMD_DIR_BIT];
      reg_addr_o <= rx_byte_q[CMD_ADDR_MSB:0];
    end
  end

  // byte counter of the data phase
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      left_q <= LEN_NONE;
    end else if (state_q == RACD_WAIT_CMD && byte_ev && cmd_ok) begin
      left_q <= cmd_len;
    end else if (state_q == RACD_XFER && byte_ev) begin
      left_q <= left_q - 2'd1;
    end
  end

  // status copy
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_i;
    end
  end

  // read value capture and byte feed, msb byte first
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_val_q <= '0;
      tx_byte_q <= TX_IDLE;
    end else if (state_q == RACD_LOAD) begin
      if (reg_addr_o == ADDR_STATUS) begin
        rd_val_q <= {16'h0000, status_q};
        tx_byte_q <= status_q;
      end else begin
        rd_val_q <= reg_rdata_i;
        tx_byte_q <= left_q == LEN_WORD ? reg_rdata_i[23:16]
                   : reg_rdata_i[15:8];
      end
    end else if (state_q == RACD_XFER && dir_rd_q && byte_ev) begin
      tx_byte_q <= left_q == LEN_WORD ? rd_val_q[15:8]
                 : left_q == LEN_CTRL ? rd_val_q[7:0] : TX_IDLE;
    end else if (state_q == RACD_WAIT_CMD) begin
      tx_byte_q <= TX_IDLE;
    end
  end

  // write data assembly, strobe after the last byte
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_wdata_o <= '0;
      reg_wr_o <= 1'b0;
    end else begin
      reg_wr_o <= state_q == RACD_XFER && !dir_rd_q && byte_ev
                  && left_q == 2'd1 && !cs_n_s;
      if (state_q == RACD_WAIT_CMD) begin
        reg_wdata_o <= '0;
      end else if (state_q == RACD_XFER && !dir_rd_q && byte_ev) begin
        reg_wdata_o <= {reg_wdata_o[15:0], rx_byte_q};
      end
    end
  end

  assign reg_rd_o = state_q == RACD_LOAD;
  assign cmd_o = cmd_q;
  assign busy_o = state_q != RACD_WAIT_CMD;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_gate_bit_ignored: assert property (
    state_q == RACD_WAIT_CMD && byte_ev && rx_byte_q[7] && !cs_n_s
    |=> state_q == RACD_WAIT_CMD && $stable(cmd_q))
    else $error("byte with top bit set taken as command");
  a_dir_bit_latch: assert property (
    state_q == RACD_WAIT_CMD && byte_ev && cmd_ok && !cs_n_s
    |=> dir_rd_q == $past(rx_byte_q[6]))
    else $error("direction not taken from bit six");
  a_addr_latch: assert property (
    state_q == RACD_WAIT_CMD && byte_ev && cmd_ok && !cs_n_s
    |=> reg_addr_o == $past(rx_byte_q[5:0]))
    else $error("target address not taken from command");
  a_reserved_code: assert property (
    state_q == RACD_WAIT_CMD && byte_ev && !rx_byte_q[7]
    && cmd_len == LEN_NONE |=> state_q == RACD_WAIT_CMD)
    else $error("reserved code opened a transfer");
  a_cmd_reset_zero: assert property (
    @(posedge clock_i) !$past(rst_n_i) |-> cmd_q == 8'h00)
    else $error("command register not zero after reset");
  a_status_read: assert property (
    state_q == RACD_LOAD && reg_addr_o == 6'h00
    |=> tx_byte_q == $past(status_q) && left_q == 2'd1)
    else $error("address zero read not from status");
  a_write_needs_cmd: assert property (
    reg_wr_o |-> $past(state_q) == RACD_XFER && !dir_rd_q)
    else $error("register write without a command");
  a_end_of_xfer: assert property (
    state_q == RACD_XFER && byte_ev && left_q == 2'd1
    |=> state_q == RACD_WAIT_CMD ##1 (left_q == 2'd0) [*2])
    else $error("no return to command wait after last byte");

  c_write_done: cover property (reg_wr_o);
  c_status_read: cover property (
    state_q == RACD_LOAD && reg_addr_o == 6'h00);
  c_word_read: cover property (
    state_q == RACD_LOAD && left_q == 2'd3 ##[1:200] state_q == RACD_WAIT_CMD);
endmodule
`default_nettype wire

// >>> test/racd_host.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the serial link; clock idles high
module racd_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // idle levels at time zero
  // select rises after reset falls, so link flops see a clean clear edge
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b0;
    sdi_o = 1'b0;
    #2;
    cs_n_o = 1'b1;
  end
  ////////////////////////////////////////
  // open or close a frame; released data shows no stale bit
  task automatic frame(input logic on);
    #100;
    cs_n_o = ~on;
    if (!on) sdi_o = ~sdi_o;
    #100;
  endtask
  // one byte, msb first: drive on falling, sample on rising
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o = tx[i];
      #62.5;
      sclk_o = 1'b1;
      rx[i] = sdo_i;
      #62.5;
    end
  endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import racd_pkg::*;
  logic clock_i;
  logic rst_n_i;
  logic sclk, cs_n, sdi, sdo_o, reg_rd_o, reg_wr_o, busy_o;
  logic [7:0] status_i;
  logic [DATA_W-1:0] reg_rdata_i;
  logic [DATA_W-1:0] reg_wdata_o;
  logic [5:0] reg_addr_o, a;
  logic [7:0] cmd_o;
  int failures = 0;
  int total_checks = 0;
  int rd_pulses = 0;
  racd_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo_o));
  racd_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo_o), .status_i(status_i),
    .reg_rdata_i(reg_rdata_i), .reg_addr_o(reg_addr_o),
    .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
    .cmd_o(cmd_o), .busy_o(busy_o));
  // 20 MHz core clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // count read strobes, sampled away from the launching edge
  always @(negedge clock_i) begin
    if (reg_rd_o === 1'b1) rd_pulses++;
  end
  ////////////////////////////////////////
  // register width in bytes per code, zero when reserved
  function automatic int nbytes(input logic [5:0] c);
    if (c == 6'h00) return 1;
    if (c inside {6'h01, 6'h02, 6'h06, 6'h07}) return 2;
    if (c >= 6'h10 && c < 6'h30) return 2;
    if (c inside {6'h03, 6'h04} || c >= 6'h30) return 3;
    return 0;
  endfunction
  // compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // closing report
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for the write strobe
  task automatic wait_wr(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge clock_i);
      #1;
      seen = reg_wr_o;
    end
  endtask
  // command then n data bytes; fewer than the width aborts
  task automatic do_write(input logic [5:0] c, input int n);
    logic [23:0] d;
    logic [7:0] b, rx;
    logic seen;
    int n0;
    d = '0;
    n0 = rd_pulses;
    i_host.frame(1'b1);
    i_host.xfer({2'b00, c}, rx);
    for (int k = 0; k < n; k++) begin
      b = 8'($urandom);
      d = {d[15:0], b};
      i_host.xfer(b, rx);
    end
    if (n == nbytes(c)) begin
      wait_wr(seen);
      chk(24'(seen), 24'h1);
      if (!seen) stop_test();
      chk(24'(reg_addr_o), 24'(c));
      chk(reg_wdata_o, d);
      chk(24'(cmd_o), {18'h0, c});
      chk(24'(busy_o), 24'h0);
      i_host.frame(1'b0);
    end else begin
      i_host.frame(1'b0);
      wait_wr(seen);
      chk(24'(seen), 24'h0);
    end
    chk(24'(rd_pulses - n0), 24'h0);
  endtask
  // read command then the register width, gaps between bytes
  task automatic do_read(input logic [5:0] c, input logic [23:0] exp);
    logic [23:0] d;
    logic [7:0] rx;
    int n0;
    d = '0;
    n0 = rd_pulses;
    i_host.frame(1'b1);
    i_host.xfer({2'b01, c}, rx);
    for (int k = 0; k < nbytes(c); k++) begin
      #500;
      i_host.xfer(8'hff, rx);
      d = {d[15:0], rx};
    end
    chk(d, exp);
    chk(24'(rd_pulses - n0), 24'h1);
    chk(24'(reg_addr_o), 24'(c));
    chk(24'(cmd_o), {16'h0, 2'b01, c});
    i_host.frame(1'b0);
  endtask
  // pick a code that names a register
  task automatic pick(input logic no_zero);
    do a = 6'($urandom); while (nbytes(a) == 0 || (no_zero && a == 0));
  endtask
  ////////////////////////////////////////
  // watchdog
  initial begin
    #4ms;
    failures++;
    stop_test();
  end
  // main sequence
  initial begin
    logic [7:0] rx;
    logic [7:0] bad [4];
    bad = '{8'h81, 8'hc2, 8'h05, 8'h0f};
    rst_n_i = 1'b1;
    status_i = 8'h00;
    reg_rdata_i = '0;
    a = 6'($urandom(32'h3283a909));
    // clean falling reset edge for the link flops
    #1;
    rst_n_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    chk(24'(cmd_o), 24'(CMD_RESET));
    chk(24'({sdo_o, busy_o}), 24'h2);
    do_write(6'h3f, 3);
    do_write(6'h10, 2);
    repeat (12) begin
      pick(1'b1);
      do_write(a, nbytes(a));
    end
    do_write(6'h30, 2);
    // refused bytes keep the last accepted command, the cut 0x30 write
    foreach (bad[j]) begin
      i_host.frame(1'b1);
      i_host.xfer(bad[j], rx);
      repeat (10) @(negedge clock_i);
      chk(24'({busy_o, cmd_o}), 24'h30);
      i_host.frame(1'b0);
    end
    // second reset between frames
    @(negedge clock_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    chk(24'({cmd_o, busy_o, sdo_o}), 24'h1);
    repeat (8) begin
      @(negedge clock_i);
      status_i = 8'($urandom);
      reg_rdata_i = 24'($urandom);
      pick(1'b0);
      if (a == 0) do_read(a, 24'(status_i));
      else do_read(a, reg_rdata_i & ~(24'hffffff << (8 * nbytes(a))));
    end
    do_read(6'h00, 24'(status_i));
    stop_test();
  end
endmodule
`default_nettype wire
